// ==== rtl/timing_trigger_sequencer.sv ====
// Timing-mode trigger sequencer: edge, pattern and timer terms over sequence levels
//
// Overview of operation
// - Each edge term matches asserting, rising, falling or either transition on a chosen line.
// - A level counts trigger-term matches and acts when the count reaches its occurrence value.
// - Pattern term can require holding longer than a minimum time before the level advances.
// - Entering a level starts the interval timers that level's timer control selects.
// - Timer-exceeded term is true once the running timer passes its limit, firing the trigger.
// - Else pattern seen before the timer limit returns the sequence to level one.
// - Two independent interval timers, each with its own limit.
// - Timers started by level two begin on the sample whose edge advanced the sequence.
// - Falling-edge term matching in level two moves the sequence to level three.
// - Level three fires when timer one is below minimum or timer two above maximum.
// - Otherwise the else branch in level three returns the sequence to level one.
`timescale 1ns/1ps
module timing_trigger_sequencer (
  input  wire logic                                 sys_clk_i,
  input  wire logic                                 reset_i,
  input  wire logic                                 ce_i,
  input  wire logic                                 arm_i,
  input  wire logic [trig_seq_pkg::LINE_W-1:0]      lines_i,
  input  wire logic [trig_seq_pkg::SEL_W-1:0]       edge_line_i      [2],
  input  wire trig_seq_pkg::edge_kind_t             edge_kind_i      [2],
  input  wire logic                                 edge_active_hi_i [2],
  input  wire logic [trig_seq_pkg::LINE_W-1:0]      pat_value_i,
  input  wire logic [trig_seq_pkg::LINE_W-1:0]      pat_care_i,
  input  wire logic [trig_seq_pkg::DUR_W-1:0]       pat_min_i,
  input  wire logic [trig_seq_pkg::TMR_W-1:0]       timer_limit_i    [trig_seq_pkg::TIMERS],
  input  wire trig_seq_pkg::term_t                  find_term_i      [trig_seq_pkg::LEVELS],
  input  wire logic [trig_seq_pkg::OCC_W-1:0]       occ_value_i      [trig_seq_pkg::LEVELS],
  input  wire logic                                 level_fires_i    [trig_seq_pkg::LEVELS],
  input  wire trig_seq_pkg::term_t                  else_term_i      [trig_seq_pkg::LEVELS],
  input  wire logic [trig_seq_pkg::LVL_W-1:0]       else_level_i     [trig_seq_pkg::LEVELS],
  input  wire logic [trig_seq_pkg::TIMERS-1:0]      timer_start_i    [trig_seq_pkg::LEVELS],
  output logic [trig_seq_pkg::LINE_W-1:0]           sample_o,
  output logic                                      trigger_o,
  output logic                                      trigger_pulse_o,
  output logic                                      armed_o,
  output logic [trig_seq_pkg::LVL_W-1:0]            level_o
);
  import trig_seq_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [LINE_W-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, prev_reg;

  // Lines are asynchronous; a change counts only once stages two and three agree
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sync1_reg <= LINES_ZERO;
      sync2_reg <= LINES_ZERO;
      sync3_reg <= LINES_ZERO;
      filt_reg  <= LINES_ZERO;
      prev_reg  <= LINES_ZERO;
    end else if (ce_i) begin
      sync1_reg <= lines_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int b = 0; b < LINE_W; b++) begin
        if (sync2_reg[b] == sync3_reg[b]) begin
          filt_reg[b] <= sync3_reg[b];
        end
      end
      prev_reg <= filt_reg;
    end
  end

  // ----------------------------------------------------------------
  // Edge and pattern terms
  // ----------------------------------------------------------------
  function automatic logic edge_match(edge_kind_t kind, logic act_hi, logic cur, logic prev);
    logic rise, fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    case (kind)
      EDGE_ASSERT: edge_match = act_hi ? rise : fall;
      EDGE_POS:    edge_match = rise;
      EDGE_NEG:    edge_match = fall;
      default:     edge_match = rise | fall;
    endcase
  endfunction

  logic [1:0]       edge_hit;
  logic             pat_match;
  logic             pat_held;
  logic [DUR_W-1:0] pat_cnt_reg;

  assign edge_hit[0] = edge_match(edge_kind_i[0], edge_active_hi_i[0],
                                  filt_reg[edge_line_i[0]], prev_reg[edge_line_i[0]]);
  assign edge_hit[1] = edge_match(edge_kind_i[1], edge_active_hi_i[1],
                                  filt_reg[edge_line_i[1]], prev_reg[edge_line_i[1]]);
  assign pat_match   = ((filt_reg ^ pat_value_i) & pat_care_i) == LINES_ZERO;
  assign pat_held    = pat_match && (pat_cnt_reg > pat_min_i);

  // Held-time counter restarts on any mismatch; saturates so long holds stay true
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pat_cnt_reg <= DUR_ZERO;
    end else if (ce_i) begin
      if (!pat_match) begin
        pat_cnt_reg <= DUR_ZERO;
      end else if (pat_cnt_reg != DUR_MAX) begin
        pat_cnt_reg <= pat_cnt_reg + DUR_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interval timers
  // ----------------------------------------------------------------
  logic [TMR_W-1:0]  tmr_cnt_reg [TIMERS];
  logic [TIMERS-1:0] tmr_run_reg;
  logic [TIMERS-1:0] tmr_over, tmr_under, start_now, stop_now;

  assign tmr_over[0]  = tmr_cnt_reg[0] > timer_limit_i[0];
  assign tmr_over[1]  = tmr_cnt_reg[1] > timer_limit_i[1];
  assign tmr_under[0] = tmr_cnt_reg[0] < timer_limit_i[0];
  assign tmr_under[1] = tmr_cnt_reg[1] < timer_limit_i[1];

  // ----------------------------------------------------------------
  // Term selection and level decisions
  // ----------------------------------------------------------------
  seq_state_t          state_reg;
  logic [LVL_W-1:0]    level_reg, next_level;
  logic [OCC_W-1:0]    occ_cnt_reg, occ_inc;
  logic [NUM_TERMS-1:0] term_vec;
  logic                find_hit, else_hit, reached, fire_now, advance, go_else, enter_now;

  assign term_vec = {tmr_under[0] | tmr_over[1], tmr_under[1], tmr_over[1], tmr_under[0],
                     tmr_over[0], pat_held, ~pat_match, pat_match, edge_hit[1], edge_hit[0],
                     1'b1, 1'b0};
  assign find_hit  = (state_reg == SEQ_SEARCH) && term_vec[find_term_i[level_reg]];
  assign else_hit  = (state_reg == SEQ_SEARCH) && term_vec[else_term_i[level_reg]];
  assign occ_inc   = occ_cnt_reg + OCC_STEP;
  assign reached   = find_hit && (occ_inc >= occ_value_i[level_reg]);
  // The awaited term wins over the else term when both hold on the sample that completes its count
  assign fire_now  = reached && level_fires_i[level_reg];
  assign advance   = reached && !level_fires_i[level_reg];
  assign go_else   = else_hit && !reached;
  assign enter_now = arm_i || advance || go_else;
  assign next_level = arm_i   ? LEVEL_ONE :
                      advance ? ((level_reg == LEVEL_LAST) ? LEVEL_LAST : level_reg + LEVEL_STEP) :
                      else_level_i[level_reg];
  assign start_now[0] = enter_now && timer_start_i[next_level][0];
  assign start_now[1] = enter_now && timer_start_i[next_level][1];
  assign stop_now     = {TIMERS{enter_now && (next_level == LEVEL_ONE)}} & ~start_now;

  // Timers count from zero on the entry sample; later entries without a start keep them running, except entry to level one, which stops them
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tmr_run_reg <= '0;
      for (int t = 0; t < TIMERS; t++) begin
        tmr_cnt_reg[t] <= TMR_ZERO;
      end
    end else if (ce_i) begin
      for (int t = 0; t < TIMERS; t++) begin
        if (start_now[t]) begin
          tmr_cnt_reg[t] <= TMR_ZERO;
          tmr_run_reg[t] <= 1'b1;
        end else if (stop_now[t]) begin
          tmr_run_reg[t] <= 1'b0;
        end else if (tmr_run_reg[t] && tmr_cnt_reg[t] != TMR_MAX) begin
          tmr_cnt_reg[t] <= tmr_cnt_reg[t] + TMR_STEP;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  logic trig_reg, pulse_reg;

  // Arming restarts from level one; trigger holds until the next arm
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg   <= SEQ_IDLE;
      level_reg   <= LEVEL_ONE;
      occ_cnt_reg <= OCC_ZERO;
      trig_reg    <= 1'b0;
      pulse_reg   <= 1'b0;
    end else if (ce_i) begin
      pulse_reg <= 1'b0;
      if (enter_now) begin
        level_reg   <= next_level;
        occ_cnt_reg <= OCC_ZERO;
      end else if (find_hit) begin
        occ_cnt_reg <= occ_inc;
      end
      case (state_reg)
        SEQ_IDLE: begin
          if (arm_i) begin
            state_reg <= SEQ_SEARCH;
          end
        end
        SEQ_SEARCH: begin
          if (arm_i) begin
            state_reg <= SEQ_SEARCH;
          end else if (fire_now) begin
            state_reg <= SEQ_FIRED;
            trig_reg  <= 1'b1;
            pulse_reg <= 1'b1;
          end
        end
        default: begin
          if (arm_i) begin
            state_reg <= SEQ_SEARCH;
            trig_reg  <= 1'b0;
          end
        end
      endcase
    end
  end

  assign sample_o        = filt_reg;
  assign trigger_o       = trig_reg;
  assign trigger_pulse_o = pulse_reg;
  assign armed_o         = (state_reg == SEQ_SEARCH);
  assign level_o         = level_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence fire_seen_s;
    ce_i && !arm_i && fire_now;
  endsequence

  sequence trig_raised_s;
    trig_reg && pulse_reg && (state_reg == SEQ_FIRED);
  endsequence

  edge_rise_a: assert property (edge_hit[0] && edge_kind_i[0] == EDGE_POS |->
    filt_reg[edge_line_i[0]] && !prev_reg[edge_line_i[0]]) else $error("edge term matched without a rise");
  occ_fire_a: assert property (fire_seen_s |=> trig_raised_s ##1 (!pulse_reg || !$past(ce_i)))
    else $error("trigger did not follow the counted match");
  pat_held_a: assert property (pat_held |-> $past(pat_match))
    else $error("pattern held true too early");
  timer_start_a: assert property (ce_i && start_now[0] |=> tmr_run_reg[0] && tmr_cnt_reg[0] == TMR_ZERO)
    else $error("timer did not start on level entry");
  timer_over_a: assert property (ce_i && !arm_i && state_reg == SEQ_SEARCH && level_fires_i[level_reg]
    && find_term_i[level_reg] == TERM_T1_OVER && occ_value_i[level_reg] <= OCC_STEP
    && tmr_cnt_reg[0] > timer_limit_i[0] |=> trig_reg) else $error("trigger missed after timer limit passed");
  else_back_a: assert property (ce_i && !arm_i && go_else && else_level_i[level_reg] == LEVEL_ONE
    |=> level_reg == LEVEL_ONE && occ_cnt_reg == OCC_ZERO) else $error("else branch did not return");
  timer_count_a: assert property (ce_i && tmr_run_reg[1] && !enter_now && tmr_cnt_reg[1] != TMR_MAX
    |=> tmr_cnt_reg[1] == $past(tmr_cnt_reg[1]) + TMR_STEP) else $error("second timer did not count");
  level_step_a: assert property (ce_i && !arm_i && advance && level_reg != LEVEL_LAST
    |=> level_reg == $past(level_reg) + LEVEL_STEP) else $error("sequence did not advance one level");
  stop_one_a: assert property (ce_i && stop_now[0] |=> !tmr_run_reg[0])
    else $error("timer kept running after return to level one");

endmodule

// ==== rtl/trig_seq_pkg.sv ====
// Constants and types shared by the timing trigger sequencer
package trig_seq_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int LINE_W = 8;   // Sampled lines of the system under test
  localparam int SEL_W  = 3;   // Line select for an edge term
  localparam int LEVELS = 4;   // Sequence levels
  localparam int LVL_W  = 2;
  localparam int OCC_W  = 8;   // Occurrence counter width
  localparam int TMR_W  = 16;  // Interval timer width, in sample clocks
  localparam int DUR_W  = 8;   // Pattern minimum duration, in sample clocks
  localparam int TIMERS = 2;

  // ----------------------------------------------------------------
  // Fixed values
  // ----------------------------------------------------------------
  localparam logic [LVL_W-1:0] LEVEL_ONE  = 2'h0;
  localparam logic [LVL_W-1:0] LEVEL_LAST = 2'h3;
  localparam logic [LVL_W-1:0] LEVEL_STEP = 2'h1;
  localparam logic [OCC_W-1:0] OCC_ZERO   = 8'h00;
  localparam logic [OCC_W-1:0] OCC_STEP   = 8'h01;
  localparam logic [TMR_W-1:0] TMR_ZERO   = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_STEP   = 16'h0001;
  localparam logic [TMR_W-1:0] TMR_MAX    = 16'hFFFF;
  localparam logic [DUR_W-1:0] DUR_ZERO   = 8'h00;
  localparam logic [DUR_W-1:0] DUR_STEP   = 8'h01;
  localparam logic [DUR_W-1:0] DUR_MAX    = 8'hFF;
  localparam logic [LINE_W-1:0] LINES_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {EDGE_ASSERT, EDGE_POS, EDGE_NEG, EDGE_EITHER} edge_kind_t;

  typedef enum logic [3:0] {
    TERM_NEVER, TERM_ANY, TERM_FIRST_EDGE_TERM, TERM_SECOND_EDGE_TERM, TERM_PAT, TERM_NOT_PAT,
    TERM_PAT_HELD, TERM_T1_OVER, TERM_T1_UNDER, TERM_T2_OVER, TERM_T2_UNDER,
    TERM_T1U_OR_T2O
  } term_t;

  localparam int NUM_TERMS = 12;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SEARCH, SEQ_FIRED} seq_state_t;

endpackage

// ==== tb/sut_lines_model.sv ====
// Behavioural model of the sampled digital lines of the system under test
`timescale 1ns/1ps
module sut_lines_model (
  input  wire logic                        sys_clk_i,
  output logic [trig_seq_pkg::LINE_W-1:0]  lines_o
);
  initial lines_o = 8'h00;

  // ------------------------------------------------------------
  // Line changes
  // ------------------------------------------------------------
  // Changes land just after a sample edge, then hold for a number of clocks
  task automatic drive(input logic [trig_seq_pkg::LINE_W-1:0] v, input int hold);
    @(posedge sys_clk_i);
    #1 lines_o = v;
    repeat (hold) @(posedge sys_clk_i);
    #1;
  endtask
endmodule

// ==== tb/timing_trigger_sequencer_bench.sv ====
// Self-checking bench for the timing trigger sequencer
`timescale 1ns/1ps
module timing_trigger_sequencer_bench;
  import trig_seq_pkg::*;
  logic              sys_clk_i = 1'b0;
  logic              reset_i   = 1'b1;
  logic              arm_i     = 1'b0;
  logic              ce        = 1'b1;
  logic [LINE_W-1:0] lines, pval, pcare, samp;
  logic [SEL_W-1:0]  eline [2];
  edge_kind_t        ekind [2];
  logic              ehi   [2];
  logic [DUR_W-1:0]  pmin;
  logic [TMR_W-1:0]  tlim  [TIMERS];
  term_t             fterm [LEVELS];
  term_t             eterm [LEVELS];
  logic [OCC_W-1:0]  occ   [LEVELS];
  logic              lfire [LEVELS];
  logic [LVL_W-1:0]  elvl  [LEVELS];
  logic [TIMERS-1:0] tstart[LEVELS];
  logic              trig, tpulse, armed;
  logic [LVL_W-1:0]  level;
  int                miscompares = 0;
  int                checks      = 0;
  int                cycles      = 0;

  sut_lines_model u_sut_lines_model (.sys_clk_i(sys_clk_i), .lines_o(lines));

  timing_trigger_sequencer u_timing_trigger_sequencer (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .ce_i(ce), .arm_i(arm_i), .lines_i(lines),
    .edge_line_i(eline), .edge_kind_i(ekind), .edge_active_hi_i(ehi), .pat_value_i(pval),
    .pat_care_i(pcare), .pat_min_i(pmin), .timer_limit_i(tlim), .find_term_i(fterm),
    .occ_value_i(occ), .level_fires_i(lfire), .else_term_i(eterm), .else_level_i(elvl),
    .timer_start_i(tstart), .sample_o(samp), .trigger_o(trig), .trigger_pulse_o(tpulse),
    .armed_o(armed), .level_o(level));

  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Defaults load under reset and tests set config before arm(), so the sequencer is never armed meanwhile
  task automatic cfg_clear();
    reset_i = 1'b1;
    for (int i = 0; i < LEVELS; i++) begin
      fterm[i] = TERM_NEVER; eterm[i] = TERM_NEVER; occ[i] = 8'h01;
      lfire[i] = 1'b0; elvl[i] = LEVEL_ONE; tstart[i] = 2'h0;
    end
    eline = '{3'h0, 3'h1}; ekind = '{EDGE_POS, EDGE_NEG}; ehi = '{1'b1, 1'b1};
    pval = 8'h00; pcare = 8'h00; pmin = 8'h00; tlim = '{16'h0000, 16'h0000};
    repeat (3) @(posedge sys_clk_i);
    #1 reset_i = 1'b0;
    u_sut_lines_model.drive(8'h00, 6);
  endtask

  task automatic arm();
    @(posedge sys_clk_i);
    #1 arm_i = 1'b1;
    @(posedge sys_clk_i);
    #1 arm_i = 1'b0;
    check("armed", armed, 1);
    check("level", level, 0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic edge_kinds();
    for (int k = 0; k < 4; k++) begin
      cfg_clear();
      eline[0] = 3'h2; ekind[0] = edge_kind_t'(k); ehi[0] = 1'b0;
      fterm[0] = TERM_FIRST_EDGE_TERM; lfire[0] = 1'b1;
      arm();
      u_sut_lines_model.drive(8'h04, 8);
      check("rise fire", trig, (k == 1 || k == 3));
      arm(); // Trigger holds until re-armed, so clear it before the falling edge
      u_sut_lines_model.drive(8'h00, 8);
      check("fall fire", trig, (k != 1));
    end
    $display("test edge_kinds done");
  endtask

  task automatic nth_assert();
    cfg_clear();
    eline[0] = 3'h5; ekind[0] = EDGE_ASSERT; fterm[0] = TERM_FIRST_EDGE_TERM; occ[0] = 8'h0A; lfire[0] = 1'b1;
    arm();
    repeat (5) begin u_sut_lines_model.drive(8'h20, 4); u_sut_lines_model.drive(8'h00, 4); end
    arm(); // Restart must forget the five seen so far
    repeat (9) begin u_sut_lines_model.drive(8'h20, 4); u_sut_lines_model.drive(8'h00, 4); end
    check("ninth", trig, 0);
    u_sut_lines_model.drive(8'h20, 0);
    for (int i = 0; i < 12 && tpulse !== 1'b1; i++) cyc(1);
    check("tenth pulse", tpulse, 1);
    check("tenth trig", trig, 1);
    cyc(1);
    check("pulse width", tpulse, 0);
    $display("test nth_assert done");
  endtask

  task automatic pattern_held();
    cfg_clear();
    pval = 8'h25; pcare = 8'h3F; pmin = 8'h04; eline[0] = 3'h7;
    fterm[0] = TERM_PAT_HELD; fterm[1] = TERM_FIRST_EDGE_TERM; lfire[1] = 1'b1; eterm[1] = TERM_NOT_PAT;
    arm();
    u_sut_lines_model.drive(8'h25, 2);
    u_sut_lines_model.drive(8'h00, 8);
    check("short hold", level, 0);
    u_sut_lines_model.drive(8'h25, 10);
    check("long hold", level, 1);
    u_sut_lines_model.drive(8'h05, 6);
    check("pattern lost", level, 0);
    u_sut_lines_model.drive(8'h25, 10);
    u_sut_lines_model.drive(8'hA5, 6);
    check("edge after hold", trig, 1);
    check("sample", samp, 8'hA5);
    $display("test pattern_held done");
  endtask

  task automatic timer_over();
    for (int d = 0; d < 2; d++) begin
      cfg_clear();
      fterm[0] = TERM_FIRST_EDGE_TERM; tstart[1] = 2'h1; fterm[1] = TERM_T1_OVER; lfire[1] = 1'b1;
      eterm[1] = TERM_PAT; pval = 8'h80; pcare = 8'h80; tlim[0] = 16'h0010;
      arm();
      u_sut_lines_model.drive(8'h01, 6);
      check("entry", level, 1);
      check("early", trig, 0);
      if (d == 0) begin
        cyc(8);
        check("below limit", trig, 0);
        cyc(12);
        check("over limit", trig, 1);
      end else begin
        u_sut_lines_model.drive(8'h81, 8);
        check("data back", level, 0);
        check("no fire", trig, 0);
      end
    end
    $display("test timer_over done");
  endtask

  task automatic pulse_limits();
    int w [3] = '{10, 35, 70};
    logic e [3] = '{1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++) begin
      cfg_clear();
      eline = '{3'h1, 3'h1}; fterm[0] = TERM_FIRST_EDGE_TERM; fterm[1] = TERM_SECOND_EDGE_TERM; tstart[1] = 2'h3;
      fterm[2] = TERM_T1U_OR_T2O; lfire[2] = 1'b1; eterm[2] = TERM_ANY; tlim = '{16'h0018, 16'h0032};
      arm();
      u_sut_lines_model.drive(8'h02, w[i]);
      u_sut_lines_model.drive(8'h00, 8);
      check("width verdict", trig, e[i]);
      if (!e[i]) check("restart", level, 0);
    end
    $display("test pulse_limits done");
  endtask

  // Under terms fire at once; the second timer's over term waits for its own limit
  task automatic timer_terms();
    term_t k [3] = '{TERM_T1_UNDER, TERM_T2_UNDER, TERM_T2_OVER};
    for (int i = 0; i < 3; i++) begin
      cfg_clear();
      tstart[0] = 2'h3; fterm[0] = k[i]; lfire[0] = 1'b1; tlim = '{16'h0004, 16'h000C};
      arm();
      cyc(6);
      check("under fire", trig, (i != 2));
      cyc(12);
      check("over fire", trig, 1);
    end
    $display("test timer_terms done");
  endtask

  // A low enable freezes the line pipeline, so an edge is seen only after release
  task automatic ce_freeze();
    cfg_clear();
    fterm[0] = TERM_FIRST_EDGE_TERM; lfire[0] = 1'b1;
    arm();
    ce = 1'b0;
    u_sut_lines_model.drive(8'h01, 10);
    check("frozen sample", samp, 8'h00);
    check("frozen trig", trig, 0);
    ce = 1'b1;
    cyc(6);
    check("thawed trig", trig, 1);
    $display("test ce_freeze done");
  endtask

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Ceiling sits well above the roughly seven hundred clocks the tests need
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    edge_kinds();
    nth_assert();
    pattern_held();
    timer_over();
    pulse_limits();
    timer_terms();
    ce_freeze();
    print_verdict();
  end
endmodule
